// file: include/oag_defines.svh
// constants for the operand address generation block
`ifndef OAG_DEFINES_SVH
`define OAG_DEFINES_SVH
`define OAG_AW          20
`define OAG_DW          16
`define OAG_ADDR_MASK   20'h0_FFFF
`define OAG_INC_BYTE    20'h0_0001
`define OAG_INC_WORD    20'h0_0002
`define OAG_INC_AWORD   20'h0_0004
`define OAG_INC_IMM     20'h0_0002
`define OAG_AL_BW_AWORD 2'h1
`define OAG_LEGACY_OPS  5'h1B
`define OAG_NREG        16
`define OAG_PC_IDX      4'h0
`define OAG_ZERO20      20'h0_0000
`define OAG_ZERO16      16'h0000
`define OAG_ZERO4       4'h0
`define OAG_ONE3        3'h1
`define OAG_TWO3        3'h2
`endif

// file: include/oag_pkg.sv
// types for the operand address generation block
package oag_pkg;
	typedef enum logic [2:0] {
		OAG_MODE_REG    = 3'h0,
		OAG_MODE_SYMB   = 3'h1,
		OAG_MODE_ABS    = 3'h2,
		OAG_MODE_IND    = 3'h3,
		OAG_MODE_AUTOINC= 3'h4,
		OAG_MODE_IMM    = 3'h5,
		OAG_MODE_IDX    = 3'h6,
		OAG_MODE_CG     = 3'h7
	} oag_mode_t;
	typedef enum logic [1:0] {
		OAG_SZ_BYTE  = 2'h0,
		OAG_SZ_WORD  = 2'h1,
		OAG_SZ_AWORD = 2'h2
	} oag_size_t;
	typedef enum logic [1:0] {
		OAG_ST_IDLE = 2'h0,
		OAG_ST_SRC  = 2'h1,
		OAG_ST_DST  = 2'h2,
		OAG_ST_DONE = 2'h3
	} oag_state_t;
endpackage

// file: verilog/oag_addr_calc.sv
// combinational operand address former for one operand
`timescale 1ns/1ps
`include "oag_defines.svh"
module oag_addr_calc
	import oag_pkg::*;
(
	input  wire oag_pkg::oag_mode_t mode,
	input  wire logic               ext_fmt,
	input  wire logic [3:0]         ext_hi,
	input  wire logic [15:0]        ext_lo,
	input  wire logic [19:0]        pc_val,
	input  wire logic [19:0]        reg_val,
	output logic      [19:0]        addr,
	output logic                    uses_word
);
	import oag_pkg::*;

	// wrap-around 20-bit add, carry past bit 19 dropped
	function automatic logic [19:0] oag_add20(input logic [19:0] a, input logic [19:0] b);
		logic [20:0] s;
		s = {1'b0, a} + {1'b0, b};
		return s[19:0];
	endfunction

	// address per mode
	always_comb begin
		addr      = `OAG_ZERO20;
		uses_word = 1'b0;
		case (mode)
			OAG_MODE_SYMB: begin
				uses_word = 1'b1;
				if (ext_fmt) begin
					addr = oag_add20(pc_val, {ext_hi, ext_lo});
				end else begin
					addr = oag_add20(pc_val, {{4{ext_lo[15]}}, ext_lo});
				end
			end
			OAG_MODE_ABS: begin
				uses_word = 1'b1;
				if (ext_fmt) begin
					addr = {ext_hi, ext_lo};
				end else begin
					addr = {`OAG_ZERO4, ext_lo};
				end
			end
			OAG_MODE_IDX: begin
				uses_word = 1'b1;
				addr      = oag_add20(reg_val, ext_fmt ? {ext_hi, ext_lo}
				                                       : {{4{ext_lo[15]}}, ext_lo});
			end
			OAG_MODE_IND, OAG_MODE_AUTOINC: begin
				addr = reg_val;
			end
			OAG_MODE_IMM: begin
				uses_word = 1'b1;
				addr      = pc_val;
			end
			default: begin
				addr = `OAG_ZERO20;
			end
		endcase
	end
endmodule

// file: verilog/oag_core.sv
// operand address generation: sequences source and destination operand addresses
`timescale 1ns/1ps
`include "oag_defines.svh"
module oag_core
	import oag_pkg::*;
(
	input  wire logic               clk,
	input  wire logic               rst,
	input  wire logic               start,
	input  wire logic               ext_fmt,
	input  wire logic               ext_al,
	input  wire logic               ext_bw,
	input  wire logic [3:0]         ext_src_hi,
	input  wire logic [3:0]         ext_dst_hi,
	input  wire oag_pkg::oag_mode_t src_mode,
	input  wire oag_pkg::oag_mode_t dst_mode,
	input  wire logic [3:0]         src_reg,
	input  wire logic [3:0]         dst_reg,
	input  wire logic [19:0]        pc_in,
	input  wire logic               mem_ready,
	input  wire logic [15:0]        mem_rdata,
	input  wire logic               reg_wr,
	input  wire logic [3:0]         reg_wr_idx,
	input  wire logic [19:0]        reg_wr_data,
	input  wire logic               call_ext,
	input  wire logic [19:0]        call_target,
	output logic                    mem_req_r,
	output logic      [19:0]        mem_addr_r,
	output logic                    src_valid_r,
	output logic      [19:0]        src_addr_r,
	output logic      [19:0]        src_imm_r,
	output logic                    dst_valid_r,
	output logic      [19:0]        dst_addr_r,
	output logic                    done_r,
	output logic      [2:0]         instr_words_r,
	output logic      [19:0]        program_counter_r,
	output logic      [19:0]        call_addr_r,
	output logic                    aword_len_r,
	output logic                    bad_mode_r
);
	import oag_pkg::*;

	oag_state_t  state_r;
	logic [19:0] regs_r [`OAG_NREG];
	logic        fetching_r;
	oag_size_t   size;
	oag_mode_t   cur_mode;
	logic [3:0]  cur_hi;
	logic [3:0]  cur_reg;
	logic [19:0] calc_addr;
	logic        calc_word;
	logic [19:0] reg_read;
	logic        src_word_need;
	logic        dst_word_need;

	////////////////////////////////////////////////////////////////////////////
	// helpers

	// 20-bit wrap-around add
	function automatic logic [19:0] oag_wrap_add(input logic [19:0] a, input logic [19:0] b);
		logic [20:0] s;
		s = {1'b0, a} + {1'b0, b};
		return s[19:0];
	endfunction

	// does this mode pull a word out of the instruction stream
	function automatic logic oag_needs_word(input oag_mode_t m);
		return (m == OAG_MODE_SYMB) || (m == OAG_MODE_ABS) ||
		       (m == OAG_MODE_IMM) || (m == OAG_MODE_IDX);
	endfunction

	// increment for post-increment mode by operand size
	function automatic logic [19:0] oag_step(input oag_size_t s);
		logic [19:0] v;
		v = `OAG_INC_WORD;
		case (s)
			OAG_SZ_BYTE:  v = `OAG_INC_BYTE;
			OAG_SZ_WORD:  v = `OAG_INC_WORD;
			OAG_SZ_AWORD: v = `OAG_INC_AWORD;
			default:      v = `OAG_INC_WORD;
		endcase
		return v;
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// operand size decode

	// al:bw = 01 means 20-bit data; legacy is never address-word
	always_comb begin
		if (ext_fmt && ({ext_al, ext_bw} == `OAG_AL_BW_AWORD)) begin
			size = OAG_SZ_AWORD;
		end else if (ext_bw) begin
			size = OAG_SZ_BYTE;
		end else begin
			size = OAG_SZ_WORD;
		end
	end

	assign src_word_need = oag_needs_word(src_mode);
	assign dst_word_need = oag_needs_word(dst_mode);

	// current operand: source in SRC state, else destination
	always_comb begin
		if (state_r == OAG_ST_SRC) begin
			cur_mode = src_mode;
			cur_hi   = ext_src_hi;
			cur_reg  = src_reg;
		end else begin
			cur_mode = dst_mode;
			cur_hi   = ext_dst_hi;
			cur_reg  = dst_reg;
		end
	end

	// pc reads come from the running counter, not the register file
	assign reg_read = (cur_reg == `OAG_PC_IDX) ? program_counter_r : regs_r[cur_reg];

	oag_addr_calc u_calc (
		.mode      (cur_mode),
		.ext_fmt   (ext_fmt),
		.ext_hi    (cur_hi),
		.ext_lo    (mem_rdata),
		.pc_val    (program_counter_r),
		.reg_val   (reg_read),
		.addr      (calc_addr),
		.uses_word (calc_word)
	);

	////////////////////////////////////////////////////////////////////////////
	// sequencer

	// one operand per state; a word operand waits for mem_ready on the fetch
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			state_r     <= OAG_ST_IDLE;
			fetching_r  <= 1'b0;
			src_valid_r <= 1'b0;
			dst_valid_r <= 1'b0;
			done_r      <= 1'b0;
			src_addr_r  <= `OAG_ZERO20;
			src_imm_r   <= `OAG_ZERO20;
			dst_addr_r  <= `OAG_ZERO20;
		end else begin
			src_valid_r <= 1'b0;
			dst_valid_r <= 1'b0;
			done_r      <= 1'b0;
			case (state_r)
				OAG_ST_IDLE: begin
					if (start) begin
						state_r <= OAG_ST_SRC;
					end
				end
				OAG_ST_SRC: begin
					if (!src_word_need || mem_ready) begin
						src_valid_r <= 1'b1;
						src_addr_r  <= calc_addr;
						if (src_mode == OAG_MODE_IMM) begin
							src_imm_r <= ext_fmt ? {ext_src_hi, mem_rdata}
							                     : {`OAG_ZERO4, mem_rdata};
						end
						state_r   <= OAG_ST_DST;
					end
				end
				OAG_ST_DST: begin
					if (!dst_word_need || mem_ready) begin
						// with auto-increment on the same register the file is already updated
						dst_valid_r <= 1'b1;
						dst_addr_r  <= calc_addr;
						state_r     <= OAG_ST_DONE;
					end
				end
				OAG_ST_DONE: begin
					done_r  <= 1'b1;
					state_r <= OAG_ST_IDLE;
				end
				default: begin
					state_r <= OAG_ST_IDLE;
				end
			endcase
		end
	end

	// memory request: the pc address while an operand word is needed
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			mem_req_r  <= 1'b0;
			mem_addr_r <= `OAG_ZERO20;
		end else begin
			mem_req_r  <= ((state_r == OAG_ST_SRC) && src_word_need && !mem_ready) ||
			              ((state_r == OAG_ST_DST) && dst_word_need && !mem_ready);
			mem_addr_r <= program_counter_r;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// program counter: steps 2 per consumed word, immediates included

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			program_counter_r <= `OAG_ZERO20;
			call_addr_r       <= `OAG_ZERO20;
		end else if (state_r == OAG_ST_IDLE && call_ext) begin
			// extended call reaches all of 1MB
			program_counter_r <= call_target;
			call_addr_r       <= call_target;
		end else if (state_r == OAG_ST_IDLE && start) begin
			program_counter_r <= pc_in;
		end else if (((state_r == OAG_ST_SRC) && src_word_need && mem_ready) ||
		             ((state_r == OAG_ST_DST) && dst_word_need && mem_ready)) begin
			program_counter_r <= oag_wrap_add(program_counter_r, `OAG_INC_IMM);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// register file with post-increment side effect

	// indirect mode leaves the register alone; auto-increment steps after the source access, except on the pc index
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			for (int i = 0; i < `OAG_NREG; i++) begin
				regs_r[i] <= `OAG_ZERO20;
			end
		end else begin
			if (reg_wr) begin
				regs_r[reg_wr_idx] <= reg_wr_data;
			end
			if ((state_r == OAG_ST_SRC) && (src_mode == OAG_MODE_AUTOINC) &&
			    (src_reg != `OAG_PC_IDX)) begin
				regs_r[src_reg] <= oag_wrap_add(regs_r[src_reg], oag_step(size));
			end
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// word count and status

	// count: instruction + extension + one word per word-needing operand
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			instr_words_r <= `OAG_ONE3;
			aword_len_r   <= 1'b0;
			bad_mode_r    <= 1'b0;
		end else if (state_r == OAG_ST_IDLE && start) begin
			// constant-generator operand adds no word, so it is one shorter
			instr_words_r <= (ext_fmt ? `OAG_TWO3 : `OAG_ONE3) +
			                 {2'b00, src_word_need} + {2'b00, dst_word_need};
			aword_len_r   <= (size == OAG_SZ_AWORD);
			// indirect kinds and immediate are source only
			bad_mode_r    <= (dst_mode == OAG_MODE_IND) || (dst_mode == OAG_MODE_AUTOINC) ||
			                 (dst_mode == OAG_MODE_IMM);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// checks

	a_legacy_abs_low: assert property (@(posedge clk) disable iff (rst)
		(state_r == OAG_ST_SRC && mem_ready && src_mode == OAG_MODE_ABS && !ext_fmt)
		|=> src_addr_r[19:16] == `OAG_ZERO4)
		else $error("legacy absolute address left lower 64KB");
	a_ext_abs_full: assert property (@(posedge clk) disable iff (rst)
		(state_r == OAG_ST_SRC && mem_ready && src_mode == OAG_MODE_ABS && ext_fmt)
		|=> src_addr_r == {$past(ext_src_hi), $past(mem_rdata)})
		else $error("extended absolute address wrong");
	a_pc_step_two: assert property (@(posedge clk) disable iff (rst)
		(state_r == OAG_ST_SRC && src_mode == OAG_MODE_IMM && mem_ready && !call_ext)
		|=> program_counter_r == oag_wrap_add($past(program_counter_r), `OAG_INC_IMM))
		else $error("pc did not advance by two after immediate");
	a_ind_unchanged: assert property (@(posedge clk) disable iff (rst)
		(state_r == OAG_ST_SRC && src_mode == OAG_MODE_IND && !reg_wr)
		|=> $stable(regs_r[src_reg]))
		else $error("indirect source register modified");
	a_sym_ext_sum: assert property (@(posedge clk) disable iff (rst)
		(state_r == OAG_ST_SRC && mem_ready && src_mode == OAG_MODE_SYMB && ext_fmt)
		|=> src_addr_r == oag_wrap_add($past(program_counter_r),
		                               {$past(ext_src_hi), $past(mem_rdata)}))
		else $error("extended symbolic address wrong");
	a_words_legacy: assert property (@(posedge clk) disable iff (rst)
		(state_r == OAG_ST_IDLE && start && !ext_fmt && src_mode == OAG_MODE_IMM)
		|=> instr_words_r == (`OAG_TWO3 + {2'b00, $past(dst_word_need)}))
		else $error("legacy immediate instruction too short");
	a_done_seq: assert property (@(posedge clk) disable iff (rst)
		dst_valid_r |=> done_r)
		else $error("done did not follow destination");
	a_aword_flag: assert property (@(posedge clk) disable iff (rst)
		(state_r == OAG_ST_IDLE && start && ext_fmt && !ext_al && ext_bw)
		|=> aword_len_r)
		else $error("address-word length not flagged");
endmodule

// file: sim/oag_mem_model.sv
// instruction-stream memory model answering operand word requests
`timescale 1ns/1ps
module oag_mem_model (
	input  wire logic        clk,
	input  wire logic        rst,
	input  wire logic [1:0]  lag,
	input  wire logic        req,
	input  wire logic [19:0] addr,
	output logic             mem_ready,
	output logic      [15:0] mem_rdata
);
	logic [15:0] mem [0:7];
	logic [1:0]  wait_r;
	logic [15:0] last_r;

	////////////////////////////////////////////////////////////////////////////////
	// slow answers hold ready back for lag cycles of a standing request
	assign mem_ready = req && (wait_r >= lag);
	// idle bus shows the inverse of the last word, so stale data never matches
	assign mem_rdata = mem_ready ? mem[addr[3:1]] : ~last_r;

	// wait counter restarts after every delivered word
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			wait_r <= 2'h0;
			last_r <= 16'h0000;
		end else begin
			if (mem_ready)
				last_r <= mem_rdata;
			if (!req || mem_ready)
				wait_r <= 2'h0;
			else if (wait_r != 2'h3)
				wait_r <= wait_r + 2'h1;
		end
	end
endmodule

// file: sim/operand_address_generation_tb_top.sv
// self-checking bench for the operand address generation core
`timescale 1ns/1ps
module operand_address_generation_tb_top;
	import oag_pkg::*;
	localparam logic [19:0] PC0 = 20'h2_1036;
	logic        clk = 1'b0;
	logic        rst = 1'b1;
	logic        start = 1'b0;
	logic        ext_fmt = 1'b0;
	logic        ext_al = 1'b0;
	logic        ext_bw = 1'b0;
	logic [3:0]  ext_src_hi = 4'h0;
	logic [3:0]  ext_dst_hi = 4'h0;
	oag_mode_t   src_mode = OAG_MODE_REG;
	oag_mode_t   dst_mode = OAG_MODE_REG;
	logic [3:0]  src_reg = 4'h0;
	logic [3:0]  dst_reg = 4'h0;
	logic        reg_wr = 1'b0;
	logic [3:0]  reg_wr_idx = 4'h0;
	logic [19:0] reg_wr_data = 20'h0_0000;
	logic        call_ext = 1'b0;
	logic [19:0] call_target = 20'h0_0000;
	logic [1:0]  lag = 2'h0;
	logic        mem_ready, mem_req_r, src_valid_r, dst_valid_r, done_r, aword_len_r, bad_mode_r;
	logic [15:0] mem_rdata;
	logic [19:0] mem_addr_r, src_addr_r, src_imm_r, dst_addr_r, program_counter_r, call_addr_r;
	logic [2:0]  instr_words_r;
	int          num_errors = 0;
	int          tests_run = 0;
	logic [19:0] first_addr = 20'h0_0000;

	always #4 clk = ~clk;

	oag_core i_oag_core (.clk(clk), .rst(rst), .start(start), .ext_fmt(ext_fmt),
		.ext_al(ext_al), .ext_bw(ext_bw), .ext_src_hi(ext_src_hi), .ext_dst_hi(ext_dst_hi),
		.src_mode(src_mode), .dst_mode(dst_mode), .src_reg(src_reg), .dst_reg(dst_reg),
		.pc_in(PC0), .mem_ready(mem_ready), .mem_rdata(mem_rdata), .reg_wr(reg_wr),
		.reg_wr_idx(reg_wr_idx), .reg_wr_data(reg_wr_data), .call_ext(call_ext),
		.call_target(call_target), .mem_req_r(mem_req_r), .mem_addr_r(mem_addr_r),
		.src_valid_r(src_valid_r), .src_addr_r(src_addr_r), .src_imm_r(src_imm_r),
		.dst_valid_r(dst_valid_r), .dst_addr_r(dst_addr_r), .done_r(done_r),
		.instr_words_r(instr_words_r), .program_counter_r(program_counter_r),
		.call_addr_r(call_addr_r), .aword_len_r(aword_len_r), .bad_mode_r(bad_mode_r));

	oag_mem_model i_oag_mem_model (.clk(clk), .rst(rst), .lag(lag), .req(mem_req_r),
		.addr(mem_addr_r), .mem_ready(mem_ready), .mem_rdata(mem_rdata));

	////////////////////////////////////////////////////////////////////////////////
	// shared helpers
	task chk(input string nm, input logic [19:0] ex, input logic [19:0] got);
		tests_run++;
		if (got !== ex) begin
			num_errors++;
			$display("unexpected %s expected %h seen %h", nm, ex, got);
		end
	endtask

	// one pulse of the register file write port, lowered 1ns after the next edge
	task wr_reg(input logic [3:0] idx, input logic [19:0] val);
		@(posedge clk);
		#1 reg_wr = 1'b1;
		reg_wr_idx = idx;
		reg_wr_data = val;
		@(posedge clk);
		#1 reg_wr = 1'b0;
	endtask

	// runs one instruction; operand words sit at PC0 and PC0+2
	task op(input logic e, input logic [1:0] sz, input logic [3:0] shi, input logic [3:0] dhi,
		input oag_mode_t sm, input oag_mode_t dm, input logic [3:0] rg,
		input logic [15:0] w0, input logic [15:0] w1);
		int n;
		int nv;
		logic seen;
		i_oag_mem_model.mem[3] = w0;
		i_oag_mem_model.mem[4] = w1;
		@(posedge clk);
		#1 {ext_fmt, ext_al, ext_bw} = {e, sz};
		{ext_src_hi, ext_dst_hi} = {shi, dhi};
		src_mode = sm;
		dst_mode = dm;
		{src_reg, dst_reg} = {rg, rg};
		start = 1'b1;
		@(posedge clk);
		#1 start = 1'b0;
		// bounded wait so a stuck sequencer cannot hang the run; count valid
		// pulses and note the address of the first delivered word
		nv = 0;
		seen = 1'b0;
		for (n = 0; n < 40 && done_r !== 1'b1; n++) begin
			@(posedge clk) #1;
			nv = nv + ((src_valid_r === 1'b1) ? 1 : 0) + ((dst_valid_r === 1'b1) ? 1 : 0);
			if (mem_ready === 1'b1 && !seen) begin
				seen = 1'b1;
				first_addr = mem_addr_r;
			end
		end
		chk("done_r", 20'h0_0001, {19'h0, done_r});
		chk("valid_pulses", 20'h0_0002, 20'(nv));
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// scenarios
	task t_symb;
		op(1'b1, 2'b10, 4'h1, 4'h5, OAG_MODE_SYMB, OAG_MODE_SYMB, 4'h0, 16'h4766, 16'h6740);
		chk("src_addr", 20'h3_579C, src_addr_r);
		chk("dst_addr", 20'h7_7778, dst_addr_r);
		chk("words", 20'h0_0004, {17'h0, instr_words_r});
		chk("first_addr", PC0, first_addr);
		chk("bad_mode", 20'h0_0000, {19'h0, bad_mode_r});
		$display("test symbolic done");
	endtask

	// slow memory here so operand words arrive late
	task t_abs;
		lag = 2'h2;
		op(1'b0, 2'b10, 4'hF, 4'hF, OAG_MODE_ABS, OAG_MODE_ABS, 4'h0, 16'hEDE0, 16'h0778);
		chk("src_addr", 20'h0_EDE0, src_addr_r);
		chk("dst_addr", 20'h0_0778, dst_addr_r);
		chk("words", 20'h0_0003, {17'h0, instr_words_r});
		op(1'b1, 2'b10, 4'h3, 4'h7, OAG_MODE_ABS, OAG_MODE_ABS, 4'h0, 16'h579C, 16'h7778);
		chk("src_addr", 20'h3_579C, src_addr_r);
		chk("dst_addr", 20'h7_7778, dst_addr_r);
		chk("words", 20'h0_0004, {17'h0, instr_words_r});
		lag = 2'h0;
		$display("test absolute done");
	endtask

	task t_ind;
		wr_reg(4'h5, 20'h3_579C);
		repeat (2) begin
			op(1'b0, 2'b10, 4'h0, 4'h0, OAG_MODE_IND, OAG_MODE_REG, 4'h5, 16'h0000, 16'h0000);
			chk("src_addr", 20'h3_579C, src_addr_r);
			chk("words", 20'h0_0001, {17'h0, instr_words_r});
		end
		$display("test indirect done");
	endtask

	// increments of 1, 2 and 4 from the top of memory must wrap
	task t_inc;
		logic [19:0] inc;
		for (int k = 0; k < 3; k++) begin
			inc = (k == 0) ? 20'h0_0001 : (k == 1) ? 20'h0_0002 : 20'h0_0004;
			wr_reg(4'h5, 20'hF_FFFF);
			op(k == 2, (k == 1) ? 2'b00 : 2'b01, 4'h0, 4'h0, OAG_MODE_AUTOINC, OAG_MODE_IDX,
				4'h5, 16'h0000, 16'h0000);
			chk("src_addr", 20'hF_FFFF, src_addr_r);
			chk("dst_addr", 20'hF_FFFF + inc, dst_addr_r);
			chk("aword", {19'h0, k == 2}, {19'h0, aword_len_r});
			chk("words", (k == 2) ? 20'h0_0003 : 20'h0_0002, {17'h0, instr_words_r});
		end
		$display("test autoincrement done");
	endtask

	task t_imm;
		op(1'b1, 2'b01, 4'h2, 4'h0, OAG_MODE_IMM, OAG_MODE_ABS, 4'h0, 16'h3456, 16'h0778);
		chk("src_imm", 20'h2_3456, src_imm_r);
		chk("dst_addr", 20'h0_0778, dst_addr_r);
		chk("first_addr", PC0, first_addr);
		chk("src_addr", PC0, src_addr_r);
		chk("pc", PC0 + 20'h0_0004, program_counter_r);
		chk("words", 20'h0_0004, {17'h0, instr_words_r});
		op(1'b0, 2'b01, 4'hF, 4'h0, OAG_MODE_IMM, OAG_MODE_ABS, 4'h0, 16'h0056, 16'h0778);
		chk("src_imm", 20'h0_0056, src_imm_r);
		chk("pc", PC0 + 20'h0_0004, program_counter_r);
		chk("words", 20'h0_0003, {17'h0, instr_words_r});
		op(1'b0, 2'b00, 4'h0, 4'h0, OAG_MODE_CG, OAG_MODE_ABS, 4'h0, 16'h0778, 16'h0000);
		chk("dst_addr", 20'h0_0778, dst_addr_r);
		chk("words", 20'h0_0002, {17'h0, instr_words_r});
		$display("test immediate done");
	endtask

	task t_bad_call;
		op(1'b0, 2'b00, 4'h0, 4'h0, OAG_MODE_REG, OAG_MODE_IND, 4'h5, 16'h0000, 16'h0000);
		chk("bad_mode", 20'h0_0001, {19'h0, bad_mode_r});
		op(1'b0, 2'b00, 4'h0, 4'h0, OAG_MODE_REG, OAG_MODE_AUTOINC, 4'h5, 16'h0000, 16'h0000);
		chk("bad_mode", 20'h0_0001, {19'h0, bad_mode_r});
		op(1'b0, 2'b00, 4'h0, 4'h0, OAG_MODE_REG, OAG_MODE_IMM, 4'h5, 16'h0000, 16'h0000);
		chk("bad_mode", 20'h0_0001, {19'h0, bad_mode_r});
		@(posedge clk);
		#1 call_ext = 1'b1;
		call_target = 20'hF_1234;
		@(posedge clk);
		#1 call_ext = 1'b0;
		@(posedge clk);
		#1 chk("call_addr", 20'hF_1234, call_addr_r);
		chk("pc", 20'hF_1234, program_counter_r);
		$display("test mode faults and call done");
	endtask

	// mid-run reset must clear the counter and the call address and reset the word count, then run again
	task t_reset;
		@(posedge clk);
		#1 rst = 1'b1;
		@(posedge clk);
		#1 chk("rst_pc", 20'h0_0000, program_counter_r);
		chk("rst_call", 20'h0_0000, call_addr_r);
		chk("rst_words", 20'h0_0001, {17'h0, instr_words_r});
		rst = 1'b0;
		op(1'b0, 2'b00, 4'h0, 4'h0, OAG_MODE_ABS, OAG_MODE_REG, 4'h0, 16'h1234, 16'h0000);
		chk("src_addr", 20'h0_1234, src_addr_r);
		chk("words", 20'h0_0002, {17'h0, instr_words_r});
		$display("test reset done");
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// verdict and run control
	task wrap_up;
		$display("comparisons %0d mismatches %0d", tests_run, num_errors);
		if (num_errors == 0 && tests_run > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask

	initial begin
		repeat (16) @(posedge clk);
		#1 rst = 1'b0;
		chk("reset_words", 20'h0_0001, {17'h0, instr_words_r});
		t_symb();
		t_abs();
		t_ind();
		t_inc();
		t_imm();
		t_bad_call();
		t_reset();
		wrap_up();
	end

	// fifteen operations of at most forty cycles fit well inside this span
	initial begin
		#40000;
		num_errors++;
		wrap_up();
	end
endmodule
